// File: design/oag_consts.svh
// constants for the operand address generator
`ifndef OAG_CONSTS_SVH
`define OAG_CONSTS_SVH
`define W16_ZERO 16'h0000
`define BYTE_ZERO 8'h00
`define NMI_VECTOR 8'h02
`define RESERVED_VEC_TOP 8'h1F
`define PORT_RSV_LO 16'h00F8
`define PORT_RSV_HI 16'h00FF
`define FLAG_IE_BIT 9
`define SEG_CODE 2'h1
`define SEG_STACK 2'h2
`define SEG_DATA 2'h3
`define SEG_EXTRA 2'h0
`endif

// File: design/oag_pkg.sv
// types shared by the operand address generator
package oag_pkg;
  typedef enum logic [2:0] {
    REF_FETCH = 3'h0,
    REF_STACK = 3'h1,
    REF_DATA = 3'h2,
    REF_STRDST = 3'h3,
    REF_OPERAND = 3'h4
  } ref_kind_t;
  typedef enum logic [2:0] {
    MODE_DISP = 3'h0,
    MODE_REGIND = 3'h1,
    MODE_BASED = 3'h2,
    MODE_INDEXED = 3'h3,
    MODE_BASEIDX = 3'h4,
    MODE_BASEIDXDISP = 3'h5
  } mem_mode_t;
  typedef enum logic [2:0] {
    VSRC_NONE = 3'h0,
    VSRC_EXCEPT = 3'h1,
    VSRC_SWINT = 3'h2,
    VSRC_NMI = 3'h3,
    VSRC_ACK = 3'h4
  } vec_src_t;
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_ACK = 2'b01,
    IRQ_PUSH = 2'b10
  } irq_state_t;
endpackage

// File: design/offset_adder.sv
// three-term 16-bit offset adder with byte displacement extension
`timescale 1ns/1ps
`default_nettype none
`include "oag_consts.svh"
module offset_adder
(
  input wire logic [15:0] dispIn, // raw displacement
  input wire logic dispIsByte, // displacement is 8-bit
  input wire logic useDisp, // include displacement
  input wire logic [15:0] baseVal, // base term
  input wire logic useBase, // include base
  input wire logic [15:0] indexVal, // index term
  input wire logic useIndex, // include index
  output logic [15:0] sum // wrapped sum
);
  logic [15:0] dispExt;
  logic [17:0] wide;
  // byte displacement is two's complement, so widen by its sign
  assign dispExt = dispIsByte ? {{8{dispIn[7]}}, dispIn[7:0]} : dispIn;
  assign wide = {2'b00, (useDisp ? dispExt : `W16_ZERO)}
              + {2'b00, (useBase ? baseVal : `W16_ZERO)}
              + {2'b00, (useIndex ? indexVal : `W16_ZERO)};
  // carries above bit 15 are dropped so offsets wrap inside 64K
  assign sum = wide[15:0];
endmodule // offset_adder
`default_nettype wire

// File: design/operand_address_generator.sv
// segment selection, offset, port address and interrupt vector sourcing
`timescale 1ns/1ps
`default_nettype none
`include "oag_consts.svh"
module operand_address_generator
  import oag_pkg::*;
(
  input wire logic ref_clk, // 200 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic addrReq, // decoder requests an address, pulse
  input wire ref_kind_t refKind, // kind of memory reference
  input wire mem_mode_t memMode, // memory operand mode
  input wire logic useBp, // base is stack base pointer, else base index
  input wire logic useDi, // index is destination index, else source
  input wire logic regIndSel, // register indirect: 0 index, 1 base
  input wire logic overrideValid, // segment override prefix present
  input wire logic [1:0] overrideSeg, // segment named by the prefix
  input wire logic [15:0] displacement, // displacement bytes
  input wire logic dispIsByte, // displacement is 8-bit
  input wire logic [15:0] instruction_pointer, // current fetch pointer
  input wire logic [15:0] base_index_register, // base index value
  input wire logic [15:0] stack_base_pointer, // stack base value
  input wire logic [15:0] source_index_register, // source index value
  input wire logic [15:0] destination_index_register, // dest index value
  input wire logic [15:0] stackPointer, // current stack pointer
  input wire logic operandReq, // non-memory operand request, pulse
  input wire logic operandIsImm, // take immediate, else general register
  input wire logic operandIsByte, // byte-wide operand
  input wire logic [15:0] immediateVal, // immediate from instruction
  input wire logic [15:0] genRegVal, // selected general register
  input wire logic portReq, // port address request, pulse
  input wire logic portFromReg, // use port pointer register
  input wire logic portIsWord, // word-wide port access
  input wire logic [7:0] portImm, // port field in instruction
  input wire logic [15:0] port_pointer_register, // port pointer value
  input wire logic exceptReq, // exception detected, pulse
  input wire logic [7:0] exceptVector, // internal exception number
  input wire logic [15:0] faultStartIp, // first byte incl. prefixes
  input wire logic swIntReq, // software interrupt, pulse
  input wire logic [7:0] swIntVector, // vector carried by instruction
  input wire logic [15:0] nextIp, // pointer after current instruction
  input wire logic nmiPin, // non-maskable request pin
  input wire logic maskable_irq_input, // maskable request pin
  input wire logic [15:0] flagsWord, // flags word
  input wire logic [15:0] codeSegSel, // code segment selector
  input wire logic [7:0] ackData, // bus data during acknowledge
  input wire logic ackDataValid, // acknowledge data strobe, pulse
  output logic addrValid, // segment and offset valid, pulse
  output logic [1:0] segIndex, // selected segment register
  output logic [15:0] offsetOut, // finished offset
  output logic operandValid, // operand valid, pulse
  output logic [15:0] operandOut, // operand value
  output logic portValid, // port address valid, pulse
  output logic [15:0] portAddr, // port address
  output logic portWord, // port access is word wide
  output logic portReserved, // port lies in reserved range
  output logic intAckCycle, // run acknowledge sequence, level
  output logic pushValid, // push word strobe, pulse
  output logic [15:0] pushData, // word to push
  output logic intVecValid, // vector ready, pulse
  output logic [7:0] intVector, // table entry number
  output logic [2:0] intVecSrc, // where the vector came from
  output logic intVecReserved // vector lies in 0-31
);
  logic [15:0] baseVal;
  logic [15:0] indexVal;
  logic useDisp;
  logic useBase;
  logic useIndex;
  logic [15:0] sumOffset;
  logic [1:0] defaultSeg;
  logic nmiMeta_reg;
  logic nmiSync_reg;
  logic nmiPrev_reg;
  logic irqMeta_reg;
  logic irqSync_reg;
  logic nmiPend_reg;
  irq_state_t irqState_reg;
  logic [1:0] pushCnt_reg;
  logic [15:0] retIp_reg;
  logic [7:0] pendVec_reg;
  vec_src_t pendSrc_reg;
  logic nmiRise;

  // term selection per memory mode
  always_comb
  begin
    baseVal = useBp ? stack_base_pointer : base_index_register;
    indexVal = useDi ? destination_index_register : source_index_register;
    useDisp = 1'b0;
    useBase = 1'b0;
    useIndex = 1'b0;
    case (memMode)
      MODE_DISP: useDisp = 1'b1;
      MODE_REGIND:
      begin
        useBase = regIndSel;
        useIndex = !regIndSel;
      end
      MODE_BASED:
      begin
        useBase = 1'b1;
        useDisp = 1'b1;
      end
      MODE_INDEXED:
      begin
        useIndex = 1'b1;
        useDisp = 1'b1;
      end
      MODE_BASEIDX:
      begin
        useBase = 1'b1;
        useIndex = 1'b1;
      end
      MODE_BASEIDXDISP:
      begin
        useBase = 1'b1;
        useIndex = 1'b1;
        useDisp = 1'b1;
      end
      default: useDisp = 1'b1;
    endcase
  end

  offset_adder adder
  (
    .dispIn(displacement),
    .dispIsByte(dispIsByte),
    .useDisp(useDisp),
    .baseVal(baseVal),
    .useBase(useBase),
    .indexVal(indexVal),
    .useIndex(useIndex),
    .sum(sumOffset)
  );

  // default segment by reference kind; a stack base pointer as base means stack
  always_comb
  begin
    case (refKind)
      REF_FETCH: defaultSeg = `SEG_CODE;
      REF_STACK: defaultSeg = `SEG_STACK;
      REF_STRDST: defaultSeg = `SEG_EXTRA;
      default: defaultSeg = (useBase && useBp) ? `SEG_STACK : `SEG_DATA;
    endcase
  end

  // segment index and offset leave in the same cycle, one pulse per request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      addrValid <= 1'b0;
      segIndex <= `SEG_CODE;
      offsetOut <= `W16_ZERO;
    end
    else
    begin
      addrValid <= addrReq;
      if (addrReq)
      begin
        // fetch and string destination cannot be overridden, the prefix steers data, operand and stack references
        if (overrideValid && refKind != REF_FETCH && refKind != REF_STRDST)
          segIndex <= overrideSeg;
        else
          segIndex <= defaultSeg;
        if (refKind == REF_FETCH)
          offsetOut <= instruction_pointer;
        else if (refKind == REF_STACK)
          offsetOut <= stackPointer;
        else
          offsetOut <= sumOffset;
      end
    end
  end

  // register and immediate operands
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      operandValid <= 1'b0;
      operandOut <= `W16_ZERO;
    end
    else
    begin
      operandValid <= operandReq;
      if (operandReq)
      begin
        if (operandIsImm)
          operandOut <= operandIsByte ? {`BYTE_ZERO, immediateVal[7:0]} : immediateVal;
        else
          operandOut <= operandIsByte ? {`BYTE_ZERO, genRegVal[7:0]} : genRegVal;
      end
    end
  end

  // port address formation; reserved range is only flagged, not blocked
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      portValid <= 1'b0;
      portAddr <= `W16_ZERO;
      portWord <= 1'b0;
      portReserved <= 1'b0;
    end
    else
    begin
      portValid <= portReq;
      if (portReq)
      begin
        portAddr <= portFromReg ? port_pointer_register : {`BYTE_ZERO, portImm};
        portWord <= portIsWord;
        if (portFromReg)
          portReserved <= port_pointer_register >= `PORT_RSV_LO
                          && port_pointer_register <= `PORT_RSV_HI;
        else
          portReserved <= {`BYTE_ZERO, portImm} >= `PORT_RSV_LO;
      end
    end
  end

  // pin synchronisers; the first stage is never looked at, the third only for the nmi edge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      nmiMeta_reg <= 1'b0;
      nmiSync_reg <= 1'b0;
      nmiPrev_reg <= 1'b0;
      irqMeta_reg <= 1'b0;
      irqSync_reg <= 1'b0;
    end
    else
    begin
      nmiMeta_reg <= nmiPin;
      nmiSync_reg <= nmiMeta_reg;
      nmiPrev_reg <= nmiSync_reg;
      irqMeta_reg <= maskable_irq_input;
      irqSync_reg <= irqMeta_reg;
    end
  end
  assign nmiRise = nmiSync_reg && !nmiPrev_reg;

  // latched edge so a busy sequencer does not lose it; new edge beats the take,
  // but an edge taken in the cycle it appears is not kept, else it is served twice
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      nmiPend_reg <= 1'b0;
    else if (nmiRise && !(irqState_reg == IRQ_IDLE && !exceptReq && !swIntReq && !nmiPend_reg))
      nmiPend_reg <= 1'b1;
    else if (irqState_reg == IRQ_IDLE && !exceptReq && !swIntReq)
      nmiPend_reg <= 1'b0;
  end

  // interrupt sequencer: pick source, optional acknowledge, push three words
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irqState_reg <= IRQ_IDLE;
      pushCnt_reg <= 2'b00;
      retIp_reg <= `W16_ZERO;
      pendVec_reg <= `BYTE_ZERO;
      pendSrc_reg <= VSRC_NONE;
      intAckCycle <= 1'b0;
      pushValid <= 1'b0;
      pushData <= `W16_ZERO;
      intVecValid <= 1'b0;
      intVector <= `BYTE_ZERO;
      intVecSrc <= VSRC_NONE;
      intVecReserved <= 1'b0;
    end
    else
    begin
      pushValid <= 1'b0;
      intVecValid <= 1'b0;
      case (irqState_reg)
        IRQ_IDLE:
        begin
          pushCnt_reg <= 2'b00;
          if (exceptReq)
          begin
            pendVec_reg <= exceptVector;
            pendSrc_reg <= VSRC_EXCEPT;
            retIp_reg <= faultStartIp;
            irqState_reg <= IRQ_PUSH;
          end
          else if (swIntReq)
          begin
            pendVec_reg <= swIntVector;
            pendSrc_reg <= VSRC_SWINT;
            retIp_reg <= nextIp;
            irqState_reg <= IRQ_PUSH;
          end
          else if (nmiPend_reg || nmiRise)
          begin
            pendVec_reg <= `NMI_VECTOR;
            pendSrc_reg <= VSRC_NMI;
            retIp_reg <= nextIp;
            irqState_reg <= IRQ_PUSH;
          end
          else if (irqSync_reg && flagsWord[`FLAG_IE_BIT])
          begin
            retIp_reg <= nextIp;
            pendSrc_reg <= VSRC_ACK;
            intAckCycle <= 1'b1;
            irqState_reg <= IRQ_ACK;
          end
        end
        IRQ_ACK:
        begin
          if (ackDataValid)
          begin
            pendVec_reg <= ackData;
            intAckCycle <= 1'b0;
            irqState_reg <= IRQ_PUSH;
          end
        end
        IRQ_PUSH:
        begin
          pushValid <= 1'b1;
          pushCnt_reg <= pushCnt_reg + 2'b01;
          // flags first, then code segment, then return pointer
          case (pushCnt_reg)
            2'b00: pushData <= flagsWord;
            2'b01: pushData <= codeSegSel;
            default: pushData <= retIp_reg;
          endcase
          if (pushCnt_reg == 2'b10)
          begin
            intVecValid <= 1'b1;
            intVector <= pendVec_reg;
            intVecSrc <= pendSrc_reg;
            intVecReserved <= pendVec_reg <= `RESERVED_VEC_TOP;
            irqState_reg <= IRQ_IDLE;
          end
        end
        default: irqState_reg <= IRQ_IDLE;
      endcase
    end
  end
endmodule // operand_address_generator
`default_nettype wire

// File: sim/operand_address_generator_assertions.sv
// port checker for the operand address generator
`timescale 1ns/1ps
`default_nettype none
`include "oag_consts.svh"
module operand_address_generator_assertions
  import oag_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic addrReq, // address request
  input wire ref_kind_t refKind, // reference kind
  input wire logic overrideValid, // prefix present
  input wire logic [1:0] overrideSeg, // prefix segment
  input wire logic addrValid, // address valid
  input wire logic [1:0] segIndex, // segment chosen
  input wire logic portReq, // port request
  input wire logic portFromReg, // port from pointer
  input wire logic [15:0] portAddr, // port address
  input wire logic intAckCycle, // acknowledge level
  input wire logic [7:0] ackData, // acknowledge byte
  input wire logic ackDataValid, // acknowledge strobe
  input wire logic pushValid, // push strobe
  input wire logic intVecValid, // vector strobe
  input wire logic [7:0] intVector, // vector
  input wire logic [2:0] intVecSrc, // vector source
  input wire logic intVecReserved // vector reserved
);
  // all checks live in the one clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_FETCH_CODE: assert property (
    addrReq && refKind == REF_FETCH |=> segIndex == `SEG_CODE) else $error("fetch segment");
  AST_STRDST_EXTRA: assert property (
    addrReq && refKind == REF_STRDST |=> segIndex == `SEG_EXTRA) else $error("dest segment");
  AST_DATA_OVERRIDE: assert property (
    addrReq && overrideValid && refKind == REF_DATA |=> segIndex == $past(overrideSeg))
    else $error("override ignored");
  AST_ADDR_PAIR: assert property (
    addrValid == $past(addrReq)) else $error("address strobe timing");
  AST_PORT_ZEXT: assert property (
    portReq && !portFromReg |=> portAddr[15:8] == 8'h00) else $error("port not zero extended");
  AST_NMI_FIXED: assert property (
    intVecValid && intVecSrc == VSRC_NMI |-> intVector == `NMI_VECTOR && !intAckCycle)
    else $error("nmi vector");
  AST_VEC_RSV: assert property (
    intVecValid |-> intVecReserved == (intVector <= `RESERVED_VEC_TOP)) else $error("vec flag");
  AST_PUSH_THREE: assert property (
    $rose(pushValid) |-> pushValid [*3] ##1 !pushValid) else $error("push count");
  AST_ACK_VEC: assert property (
    ackDataValid && intAckCycle |=> !intAckCycle ##1 pushValid ##2 intVecValid
    && intVecSrc == VSRC_ACK && intVector == $past(ackData, 4)) else $error("ack vector");
  // main scenarios reached
  cover property (intVecValid && intVecSrc == VSRC_ACK);
  cover property (intVecValid && intVecSrc == VSRC_NMI);
  cover property (addrReq && overrideValid);
endmodule // operand_address_generator_assertions
bind operand_address_generator operand_address_generator_assertions u_chk (.*);
`default_nettype wire

// File: sim/irq_source_model.sv
// external interrupt source answering the acknowledge sequence
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic raise, // bench asks for a request
  input wire logic [7:0] vecIn, // vector to hand over
  input wire logic slow, // answer late
  input wire logic intAckCycle, // acknowledge from device
  output logic maskable_irq_input, // request pin
  output logic [7:0] ackData, // bus byte
  output logic ackDataValid // byte strobe
);
  logic [3:0] waitReg;
  logic [7:0] vecReg;
  logic doneReg;
  // request held until its vector has gone out
  always_ff @(posedge ref_clk)
    if (rst) maskable_irq_input <= 1'h0;
    else if (raise) maskable_irq_input <= 1'h1;
    else if (ackDataValid) maskable_irq_input <= 1'h0;
  // one vector per acknowledge; bus shows changing junk outside the strobe
  always_ff @(posedge ref_clk)
    if (rst)
    begin
      {waitReg, vecReg, doneReg, ackData, ackDataValid} <= '0;
    end
    else
    begin
      ackDataValid <= 1'h0;
      ackData <= ~ackData;
      if (raise) vecReg <= vecIn;
      if (!intAckCycle)
      begin
        doneReg <= 1'h0;
        waitReg <= slow ? 4'h6 : 4'h1;
      end
      else if (!doneReg)
      begin
        if (waitReg == 4'h1)
        begin
          ackDataValid <= 1'h1;
          ackData <= vecReg;
          doneReg <= 1'h1;
        end
        else waitReg <= waitReg - 4'h1;
      end
    end
endmodule // irq_source_model
`default_nettype wire

// File: sim/operand_address_generator_tb_top.sv
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_tb_top;
  import oag_pkg::*;
  logic ref_clk = 1'h0, rst = 1'h1, addrReq = 1'h0, useBp = 1'h0, useDi = 1'h0;
  logic regIndSel = 1'h0, overrideValid = 1'h0, dispIsByte = 1'h0, operandReq = 1'h0;
  logic operandIsImm = 1'h0, operandIsByte = 1'h0, portReq = 1'h0, portFromReg = 1'h0;
  logic portIsWord = 1'h0, exceptReq = 1'h0, swIntReq = 1'h0, nmiPin = 1'h0;
  logic raise = 1'h0, slow = 1'h0, corner = 1'h0;
  logic [1:0] overrideSeg = 2'h0;
  logic [7:0] portImm = 8'h00, exceptVector = 8'h00, swIntVector = 8'h00, vecIn = 8'h00;
  logic [15:0] displacement = 16'h0000, instruction_pointer = 16'h0000, stackPointer = 16'h0000;
  logic [15:0] base_index_register = 16'h0000, stack_base_pointer = 16'h0000, a;
  logic [15:0] source_index_register = 16'h0000, destination_index_register = 16'h0000;
  logic [15:0] immediateVal = 16'h0000, genRegVal = 16'h0000, port_pointer_register = 16'h0000;
  logic [15:0] faultStartIp = 16'h0000, nextIp = 16'h0000, flagsWord = 16'h0000;
  logic [15:0] codeSegSel = 16'h0000;
  logic [15:0] pc [4] = '{16'h00F7, 16'h00F8, 16'h00FF, 16'h0100};
  logic [7:0] sv [4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
  ref_kind_t refKind = REF_FETCH;
  mem_mode_t memMode = MODE_DISP;
  logic addrValid, operandValid, portValid, portWord, portReserved, intAckCycle, pushValid;
  logic intVecValid, intVecReserved, maskable_irq_input, ackDataValid;
  logic [1:0] segIndex;
  logic [2:0] intVecSrc;
  logic [7:0] intVector, ackData;
  logic [15:0] offsetOut, operandOut, portAddr, pushData;
  int failures = 0, checks_done = 0, seed = 91;
  operand_address_generator u_dut (.*);
  irq_source_model u_irq (.*);
  // 200 MHz clock and a watchdog well past the expected run
  always #2.5 ref_clk = ~ref_clk;
  initial
  begin
    #200000;
    failures++;
    end_sim();
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // all-ones corners force the offset sum to wrap
  function automatic logic [15:0] rv();
    return corner ? 16'hFFFF : 16'($random(seed));
  endfunction
  function automatic logic [1:0] exp_seg();
    logic b;
    b = memMode inside {MODE_BASED, MODE_BASEIDX, MODE_BASEIDXDISP};
    b = b || (memMode == MODE_REGIND && regIndSel);
    if (refKind == REF_FETCH) return 2'h1;
    if (refKind == REF_STRDST) return 2'h0;
    if (overrideValid) return overrideSeg;
    if (refKind == REF_STACK || (b && useBp)) return 2'h2;
    return 2'h3;
  endfunction
  function automatic logic [15:0] exp_off();
    logic [15:0] d, b, x;
    d = dispIsByte ? {{8{displacement[7]}}, displacement[7:0]} : displacement;
    b = useBp ? stack_base_pointer : base_index_register;
    x = useDi ? destination_index_register : source_index_register;
    if (refKind == REF_FETCH) return instruction_pointer;
    if (refKind == REF_STACK) return stackPointer;
    case (memMode)
      MODE_DISP: return d;
      MODE_REGIND: return regIndSel ? b : x;
      MODE_BASED: return b + d;
      MODE_INDEXED: return x + d;
      MODE_BASEIDX: return b + x;
      default: return b + x + d;
    endcase
  endfunction
  // waits for the three pushes, then the vector on the last one
  task automatic serve(input logic [7:0] v, input logic [2:0] s, input logic [15:0] rip);
    int n;
    logic [15:0] w [3];
    n = 0;
    // words are taken after the edge so a flags update made at the call edge is seen
    #1;
    w = '{flagsWord, codeSegSel, rip};
    while (pushValid !== 1'h1 && n < 40)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    for (int k = 0; k < 3; k++)
    begin
      chk(pushValid, 16'h1);
      chk(pushData, w[k]);
      chk(intVecValid, k == 2);
      if (k == 2)
      begin
        chk(intVector, v);
        chk(intVecSrc, s);
        chk(intVecReserved, v <= 8'h1F);
      end
      @(posedge ref_clk);
      #1;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    for (int i = 0; i < 150; i++)
    begin
      corner = i >= 25 && i < 30;
      @(posedge ref_clk);
      addrReq <= 1'h1;
      refKind <= ref_kind_t'(i % 5);
      memMode <= mem_mode_t'((i / 5) % 6);
      {useBp, useDi, regIndSel, overrideValid, dispIsByte} <= 5'($random(seed));
      overrideSeg <= 2'($random(seed));
      {displacement, instruction_pointer, stackPointer} <= {rv(), rv(), rv()};
      {base_index_register, stack_base_pointer} <= {rv(), rv()};
      {source_index_register, destination_index_register} <= {rv(), rv()};
      @(posedge ref_clk);
      addrReq <= 1'h0;
      #1;
      chk(addrValid, 16'h1);
      chk(segIndex, exp_seg());
      chk(offsetOut, exp_off());
    end
    $display("test address done");
    for (int i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      operandReq <= 1'h1;
      {operandIsImm, operandIsByte} <= 2'($random(seed));
      {immediateVal, genRegVal} <= {rv(), rv()};
      @(posedge ref_clk);
      operandReq <= 1'h0;
      #1;
      a = operandIsImm ? immediateVal : genRegVal;
      chk(operandValid, 16'h1);
      chk(operandOut, operandIsByte ? {8'h00, a[7:0]} : a);
    end
    $display("test operand done");
    for (int i = 0; i < 24; i++)
    begin
      @(posedge ref_clk);
      portReq <= 1'h1;
      portFromReg <= (i < 4) ? 1'h1 : (i < 8) ? 1'h0 : 1'($random(seed));
      portIsWord <= 1'($random(seed));
      portImm <= (i < 8) ? pc[i % 4][7:0] : 8'($random(seed));
      port_pointer_register <= (i < 4) ? pc[i % 4] : rv();
      @(posedge ref_clk);
      portReq <= 1'h0;
      #1;
      a = portFromReg ? port_pointer_register : {8'h00, portImm};
      chk(portValid, 16'h1);
      chk(portAddr, a);
      chk(portWord, portIsWord);
      chk(portReserved, a >= 16'h00F8 && a <= 16'h00FF);
    end
    $display("test port done");
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      {flagsWord, codeSegSel, nextIp, faultStartIp} <= {rv(), rv(), rv(), rv()};
      exceptVector <= 8'($random(seed));
      swIntVector <= sv[i];
      exceptReq <= 1'h1;
      @(posedge ref_clk);
      exceptReq <= 1'h0;
      serve(exceptVector, 3'h1, faultStartIp);
      @(posedge ref_clk);
      swIntReq <= 1'h1;
      @(posedge ref_clk);
      swIntReq <= 1'h0;
      serve(swIntVector, 3'h2, nextIp);
    end
    @(posedge ref_clk);
    nmiPin <= 1'h1;
    serve(8'h02, 3'h3, nextIp);
    @(posedge ref_clk);
    nmiPin <= 1'h0;
    flagsWord <= 16'h0000;
    #1;
    chk(pushValid, 16'h0);
    $display("test internal vectors done");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      raise <= 1'h1;
      slow <= i[0];
      vecIn <= 8'($random(seed));
      @(posedge ref_clk);
      raise <= 1'h0;
      repeat (12)
      begin
        @(posedge ref_clk);
        #1;
        chk(intAckCycle, 16'h0);
      end
      @(posedge ref_clk);
      flagsWord <= 16'h0200;
      serve(vecIn, 3'h4, nextIp);
      @(posedge ref_clk);
      flagsWord <= 16'h0000;
      repeat (6) @(posedge ref_clk);
    end
    $display("test acknowledge done");
    end_sim();
  end
endmodule // operand_address_generator_tb_top
`default_nettype wire
